// [hw/lp_ctrl_pkg.sv]
// Purpose: Shared constants and types for the core low-power state control
// Assumes: Single clock mclk at 250 MHz, synchronous active-low reset
// Notes: Acknowledge codes are arbitrary encodings of the bus special cycle
package lp_ctrl_pkg;
  // Synchroniser depth for asynchronous sideband inputs
  localparam int SYNC_STAGES = 3;
  // Number of sideband inputs passed through the synchroniser bank
  localparam int SIDEBAND_W = 4;
  // Bit positions inside the synchronised sideband vector
  localparam int SB_HALT = 0;
  localparam int SB_SLEEP = 1;
  localparam int SB_MGMT = 2;
  localparam int SB_HOT = 3;
  // Reset value of the synchroniser flops (inputs are active low, idle high)
  localparam logic [SIDEBAND_W-1:0] SYNC_RESET = 4'hf;
  // Acknowledge message codes driven with the acknowledge strobe
  localparam logic [1:0] ACK_NONE = 2'h0;
  localparam logic [1:0] ACK_HALT_GRANT = 2'h1;
  localparam logic [1:0] ACK_MGMT = 2'h2;
  // Clock enable vector layout: core units, bus unit, interrupt controller
  localparam int CG_CORE = 0;
  localparam int CG_BUS = 1;
  localparam int CG_LIC = 2;
  localparam logic [2:0] CG_ALL_ON = 3'h7;
  localparam logic [2:0] CG_GRANT = 3'h6;
  localparam logic [2:0] CG_ALL_OFF = 3'h0;

  typedef enum logic [4:0] {
    ST_RUN = 5'h01,
    ST_GRANT = 5'h02,
    ST_SLEEP = 5'h04,
    ST_MGMT = 5'h08,
    ST_TRIP = 5'h10
  } lp_state_t;
endpackage

// [hw/sideband_if.sv]
// Purpose: Carries raw and synchronised sideband levels between modules
// Assumes: All signals belong to the mclk domain once synchronised
// Notes: Raw side is asynchronous to mclk
`timescale 1ns/1ps
interface sideband_if;
  logic [lp_ctrl_pkg::SIDEBAND_W-1:0] raw;
  logic [lp_ctrl_pkg::SIDEBAND_W-1:0] synced;
  modport sync_side (input raw, output synced);
  modport ctrl_side (output raw, input synced);
endinterface

// [hw/sideband_sync.sv]
// Purpose: Multi-stage synchroniser bank for asynchronous sideband inputs
// Assumes: Inputs idle high; reset value is the idle level
// Notes: Only the last stage is visible to the outside
`timescale 1ns/1ps
module sideband_sync (
  input wire logic mclk,
  input wire logic rstn,
  sideband_if.sync_side sb
);
  logic [lp_ctrl_pkg::SYNC_STAGES-1:0] chain_ff [lp_ctrl_pkg::SIDEBAND_W];

  // One shift chain per input; first stage feeds only the second
  for (genvar i = 0; i < lp_ctrl_pkg::SIDEBAND_W; i++)
  begin : g_chain
    always_ff @(posedge mclk)
    begin
      if (!rstn)
        chain_ff[i] <= '1;
      else
        chain_ff[i] <= {chain_ff[i][lp_ctrl_pkg::SYNC_STAGES-2:0], sb.raw[i]};
    end
    assign sb.synced[i] = chain_ff[i][lp_ctrl_pkg::SYNC_STAGES-1];
  end
endmodule

// [hw/lp_ctrl.sv]
// Purpose: Low-power, management-mode and thermal-trip state control of a core
// Assumes: Sideband inputs are asynchronous and active low except sensor_hot, which is active high; bus clock is mclk
// Notes: Internal clock gating is expressed as enable outputs per unit group
//
// Contract
// - Halt request enters grant state, sends acknowledge
// - Grant state gates core, keeps bus and controller
// - Grant state still snoops and services interrupts
// - Halt release restarts all clocks, resumes execution
// - Bus clock untouched; halt request is asynchronous
// - Sleep in grant state stops all clocks but PLL
// - Sleep ignores snoops and interrupts
// - Sleep reacts only to sleep, halt, reset; the code ignores halt in sleep and also leaves sleep on overheat
// - Sleep release returns to grant, restarts bus clocks
// - Management interrupt saves state, acknowledges, runs handler
// - Overheat halts execution, asserts trip output
// - Trip stays latched until reset
// - After reset, trip persists if still hot
`timescale 1ns/1ps
module lp_ctrl (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic clock_halt_request_n,
  input wire logic sleep_request_n,
  input wire logic system_mgmt_irq_n,
  input wire logic sensor_hot,
  input wire logic mgmt_resume,
  input wire logic snoop_req,
  input wire logic irq_req,
  output logic [2:0] unit_clk_en,
  output logic pll_run,
  output logic exec_en,
  output logic snoop_en,
  output logic irq_en,
  output logic ack_valid,
  output logic [1:0] ack_code,
  output logic save_state,
  output logic system_mgmt_mode,
  output logic snoop_taken,
  output logic irq_taken,
  output logic overheat_shutdown_n
);
  sideband_if sb();
  lp_ctrl_pkg::lp_state_t state_ff;
  lp_ctrl_pkg::lp_state_t nxt_state;
  logic halt_req;
  logic sleep_req;
  logic mgmt_req;
  logic hot;
  logic entering;

  // Sensor is also asynchronous, so it shares the synchroniser bank
  assign sb.raw = {~sensor_hot, system_mgmt_irq_n, sleep_request_n, clock_halt_request_n};

  sideband_sync u_sync (
    .mclk(mclk),
    .rstn(rstn),
    .sb(sb)
  );

  // Active-high views of the synchronised levels
  assign halt_req = ~sb.synced[lp_ctrl_pkg::SB_HALT];
  assign sleep_req = ~sb.synced[lp_ctrl_pkg::SB_SLEEP];
  assign mgmt_req = ~sb.synced[lp_ctrl_pkg::SB_MGMT];
  assign hot = ~sb.synced[lp_ctrl_pkg::SB_HOT];

  // Next state; overheat beats everything, trip only leaves by reset
  always_comb
  begin
    nxt_state = state_ff;
    if (hot)
      nxt_state = lp_ctrl_pkg::ST_TRIP;
    else
    begin
      unique case (state_ff)
        lp_ctrl_pkg::ST_RUN:
        begin
          if (halt_req)
            nxt_state = lp_ctrl_pkg::ST_GRANT;
          else if (mgmt_req)
            nxt_state = lp_ctrl_pkg::ST_MGMT;
        end
        lp_ctrl_pkg::ST_GRANT:
        begin
          if (sleep_req)
            nxt_state = lp_ctrl_pkg::ST_SLEEP;
          else if (!halt_req)
            nxt_state = lp_ctrl_pkg::ST_RUN;
        end
        lp_ctrl_pkg::ST_SLEEP:
        begin
          // Only sleep release and overheat matter here; halt and management inputs are not looked at
          if (!sleep_req)
            nxt_state = lp_ctrl_pkg::ST_GRANT;
        end
        lp_ctrl_pkg::ST_MGMT:
        begin
          if (halt_req)
            nxt_state = lp_ctrl_pkg::ST_GRANT;
          else if (mgmt_resume)
            nxt_state = lp_ctrl_pkg::ST_RUN;
        end
        lp_ctrl_pkg::ST_TRIP:
          nxt_state = lp_ctrl_pkg::ST_TRIP;
        default:
          nxt_state = lp_ctrl_pkg::ST_RUN;
      endcase
    end
  end

  // State register; reset clears trip, sensor decides again afterwards
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      state_ff <= lp_ctrl_pkg::ST_RUN;
    else
      state_ff <= nxt_state;
  end

  assign entering = (nxt_state != state_ff);

  // Clock enables and execution gate follow the next state to save a cycle
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      unit_clk_en <= lp_ctrl_pkg::CG_ALL_ON;
      exec_en <= 1'b1;
      pll_run <= 1'b1;
    end
    else
    begin
      unique case (nxt_state)
        lp_ctrl_pkg::ST_GRANT: unit_clk_en <= lp_ctrl_pkg::CG_GRANT;
        lp_ctrl_pkg::ST_SLEEP: unit_clk_en <= lp_ctrl_pkg::CG_ALL_OFF;
        lp_ctrl_pkg::ST_TRIP: unit_clk_en <= lp_ctrl_pkg::CG_GRANT;
        default: unit_clk_en <= lp_ctrl_pkg::CG_ALL_ON;
      endcase
      exec_en <= (nxt_state == lp_ctrl_pkg::ST_RUN) ||
                 (nxt_state == lp_ctrl_pkg::ST_MGMT);
      pll_run <= 1'b1; // PLL never stops in any state
    end
  end

  // Snoop service is open except in sleep; interrupt service is open except in sleep and trip
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      snoop_en <= 1'b1;
      irq_en <= 1'b1;
      snoop_taken <= 1'b0;
      irq_taken <= 1'b0;
    end
    else
    begin
      snoop_en <= (nxt_state != lp_ctrl_pkg::ST_SLEEP);
      irq_en <= (nxt_state != lp_ctrl_pkg::ST_SLEEP) &&
                (nxt_state != lp_ctrl_pkg::ST_TRIP);
      snoop_taken <= snoop_req && (state_ff != lp_ctrl_pkg::ST_SLEEP);
      irq_taken <= irq_req && (state_ff != lp_ctrl_pkg::ST_SLEEP) &&
                   (state_ff != lp_ctrl_pkg::ST_TRIP);
    end
  end

  // Acknowledge strobe and state save pulse, one cycle at state entry
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      ack_valid <= 1'b0;
      ack_code <= lp_ctrl_pkg::ACK_NONE;
      save_state <= 1'b0;
    end
    else
    begin
      ack_valid <= 1'b0;
      ack_code <= lp_ctrl_pkg::ACK_NONE;
      save_state <= 1'b0;
      // Sleep exit back to grant is not a fresh grant, so no second acknowledge
      if (entering && nxt_state == lp_ctrl_pkg::ST_GRANT &&
          state_ff != lp_ctrl_pkg::ST_SLEEP)
      begin
        ack_valid <= 1'b1;
        ack_code <= lp_ctrl_pkg::ACK_HALT_GRANT;
      end
      else if (entering && nxt_state == lp_ctrl_pkg::ST_MGMT)
      begin
        ack_valid <= 1'b1;
        ack_code <= lp_ctrl_pkg::ACK_MGMT;
        save_state <= 1'b1;
      end
    end
  end

  // Mode flag and trip pin; trip pin is the latched state itself
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      system_mgmt_mode <= 1'b0;
      overheat_shutdown_n <= 1'b1;
    end
    else
    begin
      system_mgmt_mode <= (nxt_state == lp_ctrl_pkg::ST_MGMT);
      overheat_shutdown_n <= (nxt_state != lp_ctrl_pkg::ST_TRIP);
    end
  end

  // Checks
  // A grant acknowledge may only go out on a fresh entry, never on the way back from sleep
  a_grant_ack: assert property (@(posedge mclk) disable iff (!rstn)
    ack_valid && ack_code == lp_ctrl_pkg::ACK_HALT_GRANT
    |-> state_ff == lp_ctrl_pkg::ST_GRANT && $past(state_ff) != lp_ctrl_pkg::ST_SLEEP)
    else $error("grant acknowledge outside grant entry");
  a_grant_pulse: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(state_ff == lp_ctrl_pkg::ST_GRANT) && $past(state_ff) == lp_ctrl_pkg::ST_RUN
    |-> ack_valid && ack_code == lp_ctrl_pkg::ACK_HALT_GRANT)
    else $error("no acknowledge on grant entry");
  a_grant_gating: assert property (@(posedge mclk) disable iff (!rstn)
    state_ff == lp_ctrl_pkg::ST_GRANT |-> unit_clk_en == lp_ctrl_pkg::CG_GRANT)
    else $error("grant clock gating wrong");
  a_grant_snoop: assert property (@(posedge mclk) disable iff (!rstn)
    state_ff == lp_ctrl_pkg::ST_GRANT && snoop_req |=> snoop_taken)
    else $error("snoop lost in grant");
  a_halt_release: assert property (@(posedge mclk) disable iff (!rstn)
    state_ff == lp_ctrl_pkg::ST_GRANT && !halt_req && !sleep_req && !hot
    |=> exec_en && unit_clk_en == lp_ctrl_pkg::CG_ALL_ON)
    else $error("halt release did not resume");
  a_halt_sync: assert property (@(posedge mclk) disable iff (!rstn)
    state_ff == lp_ctrl_pkg::ST_RUN && !clock_halt_request_n && !hot && !sensor_hot
    ##1 (!clock_halt_request_n && !sensor_hot) [*4]
    |-> state_ff != lp_ctrl_pkg::ST_RUN)
    else $error("halt request not taken after sync");
  a_sleep_stop: assert property (@(posedge mclk) disable iff (!rstn)
    state_ff == lp_ctrl_pkg::ST_SLEEP |-> unit_clk_en == lp_ctrl_pkg::CG_ALL_OFF && pll_run)
    else $error("sleep clocks wrong");
  a_sleep_deaf: assert property (@(posedge mclk) disable iff (!rstn)
    state_ff == lp_ctrl_pkg::ST_SLEEP |=> !snoop_taken && !irq_taken)
    else $error("sleep serviced a request");
  a_sleep_inputs: assert property (@(posedge mclk) disable iff (!rstn)
    state_ff == lp_ctrl_pkg::ST_SLEEP && sleep_req && !hot |=> state_ff == lp_ctrl_pkg::ST_SLEEP)
    else $error("sleep left without sleep release");
  a_sleep_exit: assert property (@(posedge mclk) disable iff (!rstn)
    state_ff == lp_ctrl_pkg::ST_SLEEP && !sleep_req && !hot
    |=> state_ff == lp_ctrl_pkg::ST_GRANT && unit_clk_en == lp_ctrl_pkg::CG_GRANT)
    else $error("sleep exit wrong");
  a_mgmt_entry: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(system_mgmt_mode) |-> save_state && ack_code == lp_ctrl_pkg::ACK_MGMT)
    else $error("management entry without save and acknowledge");
  a_trip_assert: assert property (@(posedge mclk) disable iff (!rstn)
    hot |=> !overheat_shutdown_n && !exec_en)
    else $error("overheat not halted");
  a_trip_latch: assert property (@(posedge mclk) disable iff (!rstn)
    !overheat_shutdown_n |=> !overheat_shutdown_n)
    else $error("trip released without reset");
  a_trip_reset: assert property (@(posedge mclk)
    !rstn ##1 rstn [*4] ##0 hot |=> !overheat_shutdown_n)
    else $error("trip not reasserted after reset while hot");
  a_sync_delay: assert property (@(posedge mclk) disable iff (!rstn)
    $fell(halt_req) |-> $past(clock_halt_request_n, 3))
    else $error("synchroniser depth wrong");

  // Levels that must stand for as long as a state holds
  a_run_clocks: assert property (@(posedge mclk) disable iff (!rstn)
    state_ff == lp_ctrl_pkg::ST_RUN |-> unit_clk_en == lp_ctrl_pkg::CG_ALL_ON && exec_en)
    else $error("run state clocks or execution wrong");
  a_grant_levels: assert property (@(posedge mclk) disable iff (!rstn)
    state_ff == lp_ctrl_pkg::ST_GRANT |-> !exec_en && snoop_en && irq_en)
    else $error("grant state levels wrong");
  a_grant_irq: assert property (@(posedge mclk) disable iff (!rstn)
    state_ff == lp_ctrl_pkg::ST_GRANT && irq_req |=> irq_taken)
    else $error("interrupt lost in grant");
  a_sleep_levels: assert property (@(posedge mclk) disable iff (!rstn)
    state_ff == lp_ctrl_pkg::ST_SLEEP |-> !snoop_en && !irq_en && !exec_en)
    else $error("sleep state levels wrong");
  a_sleep_mgmt: assert property (@(posedge mclk) disable iff (!rstn)
    state_ff == lp_ctrl_pkg::ST_SLEEP && sleep_req && !hot |=> !ack_valid && !system_mgmt_mode)
    else $error("sleep reacted to another input");
  a_mgmt_exec: assert property (@(posedge mclk) disable iff (!rstn)
    system_mgmt_mode |-> exec_en && unit_clk_en == lp_ctrl_pkg::CG_ALL_ON)
    else $error("handler not running in management mode");
  a_trip_deaf: assert property (@(posedge mclk) disable iff (!rstn)
    state_ff == lp_ctrl_pkg::ST_TRIP |=> !irq_taken && !exec_en)
    else $error("trip state serviced an interrupt");
  a_trip_clocks: assert property (@(posedge mclk) disable iff (!rstn)
    state_ff == lp_ctrl_pkg::ST_TRIP |-> !overheat_shutdown_n && unit_clk_en == lp_ctrl_pkg::CG_GRANT)
    else $error("trip state outputs wrong");

  // Pulses last one cycle; a longer strobe would read as a second message on the bus
  a_ack_single: assert property (@(posedge mclk) disable iff (!rstn)
    ack_valid |=> !ack_valid)
    else $error("acknowledge strobe longer than one cycle");
  a_ack_quiet: assert property (@(posedge mclk) disable iff (!rstn)
    !ack_valid |-> ack_code == lp_ctrl_pkg::ACK_NONE && !save_state)
    else $error("acknowledge code or save without strobe");

  c_grant: cover property (@(posedge mclk) disable iff (!rstn)
    state_ff == lp_ctrl_pkg::ST_GRANT);
  c_sleep: cover property (@(posedge mclk) disable iff (!rstn)
    state_ff == lp_ctrl_pkg::ST_SLEEP ##1 state_ff == lp_ctrl_pkg::ST_GRANT);
  c_mgmt: cover property (@(posedge mclk) disable iff (!rstn) $rose(system_mgmt_mode));
  c_trip: cover property (@(posedge mclk) disable iff (!rstn) $fell(overheat_shutdown_n));
  c_release: cover property (@(posedge mclk) disable iff (!rstn)
    state_ff == lp_ctrl_pkg::ST_GRANT ##1 state_ff == lp_ctrl_pkg::ST_RUN);
endmodule

// [test/sys_logic_model.sv]
// Purpose: Behavioural system core logic that drives the sideband lines
// Assumes: The bench asks for each line as an active-high wish
// Notes: Lines move a fraction of a cycle after the edge, never aligned to it
`timescale 1ns/1ps
module sys_logic_model #(
  parameter real SKEW_NS = 1.3
) (
  input wire logic mclk,
  input wire logic want_halt,
  input wire logic want_sleep,
  input wire logic want_mgmt,
  input wire logic want_hot,
  output logic clock_halt_request_n,
  output logic sleep_request_n,
  output logic system_mgmt_irq_n,
  output logic sensor_hot
);
  // Lines idle inactive from time zero
  initial
  begin
    clock_halt_request_n = 1'b1;
    sleep_request_n = 1'b1;
    system_mgmt_irq_n = 1'b1;
    sensor_hot = 1'b0;
  end

  // Skewed drive keeps the lines asynchronous, so synchroniser latency is exercised
  always @(posedge mclk)
  begin
    #(SKEW_NS);
    clock_halt_request_n <= ~want_halt;
    sleep_request_n <= ~want_sleep;
    system_mgmt_irq_n <= ~want_mgmt;
    sensor_hot <= want_hot;
  end
endmodule

// [test/cpu_low_power_state_control_test.sv]
// Purpose: Self-checking bench for the core low-power state control
// Assumes: Sideband lines come from the system logic model, skewed off the clock
// Notes: A sideband wish shows at the outputs four edges after it is set
`timescale 1ns/1ps
module cpu_low_power_state_control_test;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic want_halt = 1'b0;
  logic want_sleep = 1'b0;
  logic want_mgmt = 1'b0;
  logic want_hot = 1'b0;
  logic mgmt_resume = 1'b0;
  logic snoop_req = 1'b0;
  logic irq_req = 1'b0;
  logic halt_n, sleep_n, mgmt_n, hot;
  logic [2:0] unit_clk_en;
  logic [1:0] ack_code;
  logic pll_run, exec_en, snoop_en, irq_en, ack_valid, save_state;
  logic system_mgmt_mode, snoop_taken, irq_taken, overheat_shutdown_n;
  int miscompares = 0;
  int num_checks = 0;

  // 250 MHz bus clock
  always #2 mclk = ~mclk;

  sys_logic_model sys_model (.mclk(mclk), .want_halt(want_halt), .want_sleep(want_sleep),
    .want_mgmt(want_mgmt), .want_hot(want_hot), .clock_halt_request_n(halt_n),
    .sleep_request_n(sleep_n), .system_mgmt_irq_n(mgmt_n), .sensor_hot(hot));

  lp_ctrl uut (.mclk(mclk), .rstn(rstn), .clock_halt_request_n(halt_n),
    .sleep_request_n(sleep_n), .system_mgmt_irq_n(mgmt_n), .sensor_hot(hot),
    .mgmt_resume(mgmt_resume), .snoop_req(snoop_req), .irq_req(irq_req),
    .unit_clk_en(unit_clk_en), .pll_run(pll_run), .exec_en(exec_en), .snoop_en(snoop_en),
    .irq_en(irq_en), .ack_valid(ack_valid), .ack_code(ack_code), .save_state(save_state),
    .system_mgmt_mode(system_mgmt_mode), .snoop_taken(snoop_taken), .irq_taken(irq_taken),
    .overheat_shutdown_n(overheat_shutdown_n));

  task automatic chk(input string what, input logic [2:0] exp, input logic [2:0] got);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Sample just after the edge so its updates have landed
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic apply(input logic h, input logic s, input logic m, input logic t);
    @(posedge mclk);
    want_halt <= h;
    want_sleep <= s;
    want_mgmt <= m;
    want_hot <= t;
  endtask

  task automatic do_reset();
    @(posedge mclk);
    rstn <= 1'b0;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
  endtask

  // One-cycle snoop and interrupt; the taken pulse stands one cycle, so look right after it lands
  task automatic pulse_req(input logic exp_snoop, input logic exp_irq);
    @(posedge mclk);
    snoop_req <= 1'b1;
    irq_req <= 1'b1;
    @(posedge mclk);
    snoop_req <= 1'b0;
    irq_req <= 1'b0;
    #1;
    chk("snoop_taken", exp_snoop, snoop_taken);
    chk("irq_taken", exp_irq, irq_taken);
  endtask

  task automatic resume();
    @(posedge mclk);
    mgmt_resume <= 1'b1;
    @(posedge mclk);
    mgmt_resume <= 1'b0;
    tick(1);
  endtask

  task automatic t_halt_sleep();
    apply(1'b1, 1'b0, 1'b0, 1'b0);
    tick(3);
    chk("clk_en early", lp_ctrl_pkg::CG_ALL_ON, unit_clk_en);
    tick(1);
    chk("halt ack", 1'b1, ack_valid);
    chk("halt code", lp_ctrl_pkg::ACK_HALT_GRANT, ack_code);
    chk("grant clk_en", lp_ctrl_pkg::CG_GRANT, unit_clk_en);
    chk("grant exec", 1'b0, exec_en);
    chk("grant pll", 1'b1, pll_run);
    tick(1);
    chk("ack pulse", 1'b0, ack_valid);
    pulse_req(1'b1, 1'b1);
    apply(1'b1, 1'b1, 1'b1, 1'b0);
    tick(4);
    chk("sleep clk_en", lp_ctrl_pkg::CG_ALL_OFF, unit_clk_en);
    chk("sleep pll", 1'b1, pll_run);
    chk("sleep snoop_en", 1'b0, snoop_en);
    pulse_req(1'b0, 1'b0);
    resume();
    chk("sleep mgmt", 1'b0, system_mgmt_mode);
    chk("sleep ack", 1'b0, ack_valid);
    apply(1'b1, 1'b0, 1'b0, 1'b0);
    tick(4);
    chk("wake clk_en", lp_ctrl_pkg::CG_GRANT, unit_clk_en);
    chk("wake no ack", 1'b0, ack_valid);
    chk("wake irq_en", 1'b1, irq_en);
    apply(1'b0, 1'b0, 1'b0, 1'b0);
    tick(4);
    chk("run clk_en", lp_ctrl_pkg::CG_ALL_ON, unit_clk_en);
    chk("run exec", 1'b1, exec_en);
  endtask

  // Sleep outside the grant state must change nothing
  task automatic t_sleep_run();
    apply(1'b0, 1'b1, 1'b0, 1'b0);
    tick(4);
    chk("run sleep clk_en", lp_ctrl_pkg::CG_ALL_ON, unit_clk_en);
    apply(1'b0, 1'b0, 1'b0, 1'b0);
    tick(4);
  endtask

  task automatic t_mgmt();
    apply(1'b0, 1'b0, 1'b1, 1'b0);
    tick(4);
    chk("mgmt mode", 1'b1, system_mgmt_mode);
    chk("mgmt save", 1'b1, save_state);
    chk("mgmt ack", 1'b1, ack_valid);
    chk("mgmt code", lp_ctrl_pkg::ACK_MGMT, ack_code);
    tick(1);
    chk("mgmt save pulse", 1'b0, save_state);
    chk("mgmt exec", 1'b1, exec_en);
    apply(1'b0, 1'b0, 1'b0, 1'b0);
    tick(4);
    resume();
    chk("mgmt exit", 1'b0, system_mgmt_mode);
  endtask

  task automatic t_overheat();
    apply(1'b0, 1'b0, 1'b0, 1'b1);
    tick(4);
    chk("trip out", 1'b0, overheat_shutdown_n);
    chk("trip exec", 1'b0, exec_en);
    pulse_req(1'b1, 1'b0);
    apply(1'b1, 1'b0, 1'b0, 1'b0);
    tick(4);
    chk("cool trip", 1'b0, overheat_shutdown_n);
    chk("cool exec", 1'b0, exec_en);
    apply(1'b0, 1'b0, 1'b0, 1'b1);
    tick(4);
    do_reset();
    tick(6);
    chk("hot reset trip", 1'b0, overheat_shutdown_n);
    apply(1'b0, 1'b0, 1'b0, 1'b0);
    tick(4);
    do_reset();
    tick(6);
    chk("cool reset trip", 1'b1, overheat_shutdown_n);
    chk("cool reset exec", 1'b1, exec_en);
  endtask

  task automatic final_report();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Whole sequence needs well under a thousand cycles
  initial
  begin
    #20000;
    miscompares++;
    final_report();
  end

  initial
  begin
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    tick(1);
    chk("reset clk_en", lp_ctrl_pkg::CG_ALL_ON, unit_clk_en);
    chk("reset trip", 1'b1, overheat_shutdown_n);
    t_halt_sleep();
    t_sleep_run();
    t_mgmt();
    t_overheat();
    final_report();
  end
endmodule
